// >>> logic/fshs_consts.svh
// Purpose: Named constants for the sync header stream encoder
// Assumes: Included by the package and by every design file
// Notes: Offsets are byte addresses on the plain register port
`ifndef FSHS_CONSTS_SVH
`define FSHS_CONSTS_SVH

// Register map
`define FSHS_REG_CTRL 8'h00
`define FSHS_REG_STATUS 8'h04
`define FSHS_REG_FEC 8'h08
`define FSHS_REG_CRC 8'h0c
`define FSHS_REG_MBCNT 8'h10

// Control fields
`define FSHS_CTRL_EN_BIT 0
`define FSHS_CTRL_MODE_LSB 4
`define FSHS_CTRL_EMPH_LSB 8
`define FSHS_EN_RST 1'h0
`define FSHS_MODE_RST 2'h0
`define FSHS_EMPH_RST 4'h0

// Status fields
`define FSHS_STAT_BLK_LSB 8
`define FSHS_STAT_MB_LSB 16

// Sync header mode select values
`define FSHS_MODE_CRC12 2'h0
`define FSHS_MODE_FEC 2'h2

// Multiblock framing
`define FSHS_LAST_BLK 5'h1f
`define FSHS_PILOT 5'h01
`define FSHS_PILOT_POS 27
`define FSHS_EXTENDED_MULTIBLOCK_END_FLAG_POS 22
`define FSHS_FEC_LOW_POS 23
`define FSHS_FEC_TAIL_POS 24
`define FSHS_FEC_SPLIT 4
`define FSHS_CRC_ONES 32'h00a88888

// Generator polynomials, leading term implied
`define FSHS_FEC_POLY 26'h0220211
`define FSHS_CRC_POLY 12'h30f

`endif

// >>> logic/fshs_pkg.sv
// Purpose: Types shared by the sync header stream encoder
// Assumes: Constants come from fshs_consts.svh
// Notes: Encoder and timer state is carried as packed structs
`include "fshs_consts.svh"
package fshs_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fshs_bus_req_t;

    // Header [0] goes on the line first
    typedef struct packed {
        logic [1:0] hdr;
        logic [63:0] payload;
    } fshs_block_t;

    typedef struct packed {
        logic [4:0] blk;
        logic [7:0] mb;
    } fshs_tmr_state_t;

    typedef struct packed {
        logic linkEnable;
        logic [1:0] mode;
        logic [3:0] emph;
        logic [25:0] fecRun;
        logic [11:0] crcRun;
        logic [25:0] fecHeld;
        logic [11:0] crcHeld;
        fshs_block_t outBlk;
        logic outVld;
        logic [4:0] outIdx;
        logic [15:0] mbCount;
        logic [31:0] rdData;
    } fshs_enc_state_t;

endpackage

// >>> logic/fshs_parity_step.sv
// Purpose: One block (64 bits) of a serial cyclic parity divider
// Assumes: Bit 0 of the data is the first bit on the line
// Notes: Purely combinational; the caller holds the state
`include "fshs_consts.svh"
module fshs_parity_step
    import fshs_pkg::*;
#(
    parameter int W = 26,
    parameter logic [W-1:0] POLY = `FSHS_FEC_POLY
)
(
    // Divider state and block
    input wire logic [W-1:0] seed,
    input wire logic [63:0] data,
    // Updated state
    output logic [W-1:0] next
);

    // Same result as shifting one bit per clock in line order
    function automatic logic [W-1:0] step(input logic [W-1:0] s,
                                          input logic [63:0] d);
        logic [W-1:0] r;
        logic fb;
        r = s;
        fb = 1'b0;
        for (int i = 0; i < 64; i++)
        begin
            fb = d[i] ^ r[W-1];
            r = {r[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
        return r;
    endfunction

    assign next = step(seed, data);

endmodule

// >>> logic/fshs_emb_timer.sv
// Purpose: Block and multiblock position inside the extended multiblock
// Assumes: sysref is a one-cycle pulse in the block clock domain
// Notes: sysref wins over an advance in the same cycle
`include "fshs_consts.svh"
module fshs_emb_timer
    import fshs_pkg::*;
#(
    parameter logic [7:0] EMB_LEN = 8'h01
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic sysref,
    input wire logic advance,
    // Position
    output logic [4:0] blkIdx,
    output logic [7:0] mbIdx,
    output logic mbLast,
    output logic embLast
);

    fshs_tmr_state_t st_r;
    fshs_tmr_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (!enable || sysref)
        begin
            st_nxt = '0;
        end
        else if (advance)
        begin
            st_nxt.blk = st_r.blk + 5'h01;
            if (st_r.blk == `FSHS_LAST_BLK)
            begin
                st_nxt.mb = embLast ? 8'h00 : st_r.mb + 8'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign blkIdx = st_r.blk;
    assign mbIdx = st_r.mb;
    assign mbLast = (st_r.blk == `FSHS_LAST_BLK);
    assign embLast = (st_r.mb == EMB_LEN - 8'h01);

    a_mb_wrap: assert property (@(posedge clk) disable iff (rst)
        enable && !sysref && advance && mbLast && embLast
        |=> mbIdx == 8'h00 && blkIdx == 5'h00)
        else $error("multiblock index did not wrap");

    a_sysref_zero: assert property (@(posedge clk) disable iff (rst)
        sysref |=> blkIdx == 5'h00 && mbIdx == 8'h00)
        else $error("sysref did not reset position");

endmodule

// >>> logic/fshs_encoder.sv
// Purpose: Transmit sync header stream encoder, FEC and CRC-12 modes
// Assumes: One scrambled 64-bit block per accepted cycle, bit 0 first
// Notes: Parity of one multiblock rides in the next multiblock
`include "fshs_consts.svh"

module fshs_encoder
    import fshs_pkg::*;
#(
    parameter logic [7:0] EMB_LEN = 8'h01
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire fshs_bus_req_t busReq,
    output logic [31:0] busRdData,
    // Scrambled block input
    input wire logic [63:0] inBlock,
    input wire logic inValid,
    output logic inReady,
    // Extended multiblock timing reset
    input wire logic sysref,
    // Encoded block output
    output fshs_block_t outBlock,
    output logic outValid,
    // Serializer drive
    output logic [3:0] serializerEmphasisLevel,
    output logic linkActive
);

    fshs_enc_state_t st_r;
    fshs_enc_state_t st_nxt;

    logic accept;
    logic [4:0] blkIdx;
    logic [7:0] mbIdx;
    logic mbLast;
    logic embLast;
    logic [25:0] fecSeed;
    logic [11:0] crcSeed;
    logic [25:0] fecNext;
    logic [11:0] crcNext;
    logic [31:0] stream;
    logic outIdx27;
    logic outIdxEnd;

    // Pilot goes out most significant bit first
    localparam logic [4:0] PILOT = `FSHS_PILOT;

    // FEC stream layout
    function automatic logic [31:0] fec_stream(input logic [25:0] p,
                                               input logic emb);
        logic [31:0] s;
        s = '0;
        for (int i = 0; i < 26 - `FSHS_FEC_SPLIT; i++)
        begin
            s[i] = p[25-i];
        end
        s[`FSHS_EXTENDED_MULTIBLOCK_END_FLAG_POS] = emb;
        s[`FSHS_FEC_LOW_POS] = p[3];
        for (int i = 0; i < 3; i++)
        begin
            s[`FSHS_FEC_TAIL_POS+i] = p[2-i];
        end
        for (int i = 0; i < 5; i++)
        begin
            s[`FSHS_PILOT_POS+i] = PILOT[4-i];
        end
        return s;
    endfunction

    // CRC-12 stream layout, command bits always zero
    function automatic logic [31:0] crc_stream(input logic [11:0] p,
                                               input logic emb);
        logic [31:0] s;
        s = `FSHS_CRC_ONES;
        for (int k = 0; k < 12; k++)
        begin
            s[(k / 3) * 4 + (k % 3)] = p[11-k];
        end
        s[`FSHS_EXTENDED_MULTIBLOCK_END_FLAG_POS] = emb;
        for (int i = 0; i < 5; i++)
        begin
            s[`FSHS_PILOT_POS+i] = PILOT[4-i];
        end
        return s;
    endfunction

    // Link held in reset while disabled, so no input is taken
    assign inReady = st_r.linkEnable;
    assign accept = inValid && inReady && !sysref;

    fshs_emb_timer #(
        .EMB_LEN(EMB_LEN)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .enable(st_r.linkEnable),
        .sysref(sysref),
        .advance(accept),
        .blkIdx(blkIdx),
        .mbIdx(mbIdx),
        .mbLast(mbLast),
        .embLast(embLast)
    );

    // Fresh zero seed on the first block of every multiblock
    assign fecSeed = (blkIdx == 5'h00) ? 26'h0 : st_r.fecRun;
    assign crcSeed = (blkIdx == 5'h00) ? 12'h0 : st_r.crcRun;

    fshs_parity_step #(
        .W(26),
        .POLY(`FSHS_FEC_POLY)
    ) u_fec (
        .seed(fecSeed),
        .data(inBlock),
        .next(fecNext)
    );

    fshs_parity_step #(
        .W(12),
        .POLY(`FSHS_CRC_POLY)
    ) u_crc (
        .seed(crcSeed),
        .data(inBlock),
        .next(crcNext)
    );

    // Held parity belongs to the previous multiblock
    always_comb
    begin
        if (st_r.mode == `FSHS_MODE_FEC)
        begin
            stream = fec_stream(st_r.fecHeld, embLast);
        end
        else
        begin
            stream = crc_stream(st_r.crcHeld, embLast);
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.outVld = 1'b0;
        if (busReq.wr && busReq.addr == `FSHS_REG_CTRL)
        begin
            st_nxt.linkEnable = busReq.wdata[`FSHS_CTRL_EN_BIT];
            st_nxt.mode = busReq.wdata[`FSHS_CTRL_MODE_LSB +: 2];
            st_nxt.emph = busReq.wdata[`FSHS_CTRL_EMPH_LSB +: 4];
        end
        if (busReq.rd)
        begin
            case (busReq.addr)
                `FSHS_REG_CTRL:
                begin
                    st_nxt.rdData = '0;
                    st_nxt.rdData[`FSHS_CTRL_EN_BIT] = st_r.linkEnable;
                    st_nxt.rdData[`FSHS_CTRL_MODE_LSB +: 2] = st_r.mode;
                    st_nxt.rdData[`FSHS_CTRL_EMPH_LSB +: 4] = st_r.emph;
                end
                `FSHS_REG_STATUS:
                begin
                    st_nxt.rdData = '0;
                    st_nxt.rdData[`FSHS_CTRL_EN_BIT] = st_r.linkEnable;
                    st_nxt.rdData[`FSHS_STAT_BLK_LSB +: 5] = blkIdx;
                    st_nxt.rdData[`FSHS_STAT_MB_LSB +: 8] = mbIdx;
                end
                `FSHS_REG_FEC:
                begin
                    st_nxt.rdData = {6'h00, st_r.fecHeld};
                end
                `FSHS_REG_CRC:
                begin
                    st_nxt.rdData = {20'h00000, st_r.crcHeld};
                end
                `FSHS_REG_MBCNT:
                begin
                    st_nxt.rdData = {16'h0000, st_r.mbCount};
                end
                default:
                begin
                    st_nxt.rdData = '0;
                end
            endcase
        end
        if (!st_r.linkEnable || sysref)
        begin
            // Timing restart: partial multiblock parity is dropped
            st_nxt.fecRun = '0;
            st_nxt.crcRun = '0;
        end
        if (!st_r.linkEnable)
        begin
            st_nxt.fecHeld = '0;
            st_nxt.crcHeld = '0;
        end
        else if (accept)
        begin
            // Payload only: headers are added after the divider
            st_nxt.fecRun = fecNext;
            st_nxt.crcRun = crcNext;
            st_nxt.outBlk.payload = inBlock;
            // Sync header [0:1] of 01 sends a one
            st_nxt.outBlk.hdr = {stream[blkIdx], ~stream[blkIdx]};
            st_nxt.outVld = 1'b1;
            st_nxt.outIdx = blkIdx;
            if (mbLast)
            begin
                // Sent from position 0 of the next multiblock onward
                st_nxt.fecHeld = fecNext;
                st_nxt.crcHeld = crcNext;
                st_nxt.mbCount = st_r.mbCount + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.linkEnable <= `FSHS_EN_RST;
            st_r.mode <= `FSHS_MODE_RST;
            st_r.emph <= `FSHS_EMPH_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign busRdData = st_r.rdData;
    assign outBlock = st_r.outBlk;
    assign outValid = st_r.outVld;
    assign serializerEmphasisLevel = st_r.emph;
    assign linkActive = st_r.linkEnable;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_header_pair: assert property (
        outValid |-> outBlock.hdr[0] != outBlock.hdr[1])
        else $error("sync header bits not opposite");

    a_pilot_tail: assert property (
        outValid && outIdx27 |-> outBlock.hdr[1] == (outIdxEnd))
        else $error("pilot pattern wrong");

    a_fec_upper: assert property (
        outValid && st_r.mode == `FSHS_MODE_FEC && st_r.outIdx < 5'd22
        |-> outBlock.hdr[1] == st_r.fecHeld[5'd25 - st_r.outIdx])
        else $error("FEC upper parity bit misplaced");

    a_fec_bit3: assert property (
        outValid && st_r.mode == `FSHS_MODE_FEC && st_r.outIdx == 5'd23
        |-> outBlock.hdr[1] == st_r.fecHeld[3])
        else $error("FEC parity bit 3 misplaced");

    a_extended_multiblock_end_flag_flag: assert property (
        outValid && st_r.outIdx == 5'd22 && st_r.linkEnable
        |-> outBlock.hdr[1] == (mbIdx == EMB_LEN - 8'h01))
        else $error("extended multiblock end flag wrong");

    a_crc_ones: assert property (
        outValid && st_r.mode == `FSHS_MODE_CRC12 && st_r.outIdx == 5'd3
        |-> outBlock.hdr[1])
        else $error("CRC-12 fixed one missing");

    a_held_stable: assert property (
        st_r.linkEnable && accept && !mbLast |=> $stable(st_r.fecHeld))
        else $error("held parity changed mid multiblock");

    a_parity_clear: assert property (
        st_r.linkEnable && accept && blkIdx == 5'h00 && inBlock == '0
        |=> st_r.fecRun == 26'h0 && st_r.crcRun == 12'h0)
        else $error("parity not cleared at multiblock start");

    a_mb_count: assert property (
        st_r.linkEnable && accept && mbLast
        |=> st_r.mbCount == $past(st_r.mbCount) + 16'h0001)
        else $error("multiblock count not advanced");

    a_emph_write: assert property (
        busReq.wr && busReq.addr == `FSHS_REG_CTRL
        |=> serializerEmphasisLevel ==
            $past(busReq.wdata[`FSHS_CTRL_EMPH_LSB +: 4]))
        else $error("emphasis level not taken");

    a_fec_tail: assert property (
        outValid && st_r.mode == `FSHS_MODE_FEC && st_r.outIdx >= 5'd24
        && st_r.outIdx <= 5'd26
        |-> outBlock.hdr[1] == st_r.fecHeld[5'd26 - st_r.outIdx])
        else $error("FEC low parity bits misplaced");

    a_crc_cmd: assert property (
        outValid && st_r.mode == `FSHS_MODE_CRC12 && st_r.outIdx == 5'd16
        |-> !outBlock.hdr[1])
        else $error("CRC-12 command bit not zero");

    a_out_follows: assert property (
        accept |=> outValid && outBlock.payload == $past(inBlock))
        else $error("taken block not passed on");

    // Blocks dropped by sysref must leave the lane quiet
    a_idle_quiet: assert property (
        !accept |=> !outValid)
        else $error("header sent for a block not taken");

    // A link brought up again starts with zero parity in its stream
    a_held_clear: assert property (
        !st_r.linkEnable |=> st_r.fecHeld == 26'h0)
        else $error("held parity survived link disable");

    a_ctrl_read: assert property (
        busReq.rd && busReq.addr == `FSHS_REG_CTRL
        |=> busRdData[`FSHS_CTRL_EMPH_LSB +: 4] == $past(st_r.emph))
        else $error("emphasis level read back wrong");

    assign outIdx27 = st_r.outIdx >= 5'd27;
    assign outIdxEnd = st_r.outIdx == `FSHS_LAST_BLK;

endmodule

// >>> sim/fshs_rx_model.sv
// Purpose: Receiver model that unpacks the sync header stream
// Assumes: One encoded block per rxVld pulse, hdr[0] first on line
// Notes: Own serial divider, so parity never comes from the encoder
`include "fshs_consts.svh"
module fshs_rx_model
    import fshs_pkg::*;
#(
    parameter logic [7:0] EMB_LEN = 8'h01
)
(
    // Clock and clear
    input wire logic clk,
    input wire logic clr,
    // Lane from the encoder
    input wire fshs_block_t rxBlk,
    input wire logic rxVld,
    // Captured multiblocks
    output logic [31:0] words [4],
    output logic [25:0] par [4],
    output int mbSeen,
    output int lineErrs
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] acc;
    logic [25:0] run;
    logic fb;
    logic embExp;
    int idx;

    always @(posedge clk)
    begin
        if (clr)
        begin
            // Capture restarts at an extended multiblock start
            idx = 0;
            mbSeen = 0;
            lineErrs = 0;
            run = '0;
        end
        else if (rxVld)
        begin
            // Equal header bits cannot carry a stream bit
            if (rxBlk.hdr[0] == rxBlk.hdr[1]) lineErrs++;
            acc[idx] = rxBlk.hdr[1];
            for (int i = 0; i < 64; i++)
            begin
                fb = rxBlk.payload[i] ^ run[25];
                run = {run[24:0], 1'b0} ^ (fb ? `FSHS_FEC_POLY : 26'h0);
            end
            if (idx == 31)
            begin
                // Pilot checked every time, one match proves nothing
                if (acc[31:27] != 5'h10) lineErrs++;
                embExp = ((mbSeen % int'(EMB_LEN)) == int'(EMB_LEN) - 1);
                if (acc[22] != embExp) lineErrs++;
                if (mbSeen < 4)
                begin
                    words[mbSeen] = acc;
                    par[mbSeen] = run;
                end
                mbSeen++;
                run = '0;
                idx = 0;
            end
            else
                idx++;
        end
    end
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the sync header stream encoder
// Assumes: 200 MHz clock, two multiblocks per extended multiblock
// Notes: Expected parity comes from the receiver model's divider
`include "fshs_consts.svh"
module tb import fshs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] EMB = 8'h02;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fshs_bus_req_t busReq = '0;
    logic [31:0] busRdData;
    logic [63:0] inBlock = '0;
    logic inValid = 1'b0;
    logic inReady;
    logic sysref = 1'b0;
    fshs_block_t outBlock;
    logic outValid;
    logic [3:0] serializerEmphasisLevel;
    logic linkActive;
    logic clr = 1'b1;
    logic [31:0] words [4];
    logic [25:0] par [4];
    int mbSeen;
    int lineErrs;
    int miscompares = 0;
    int samples_checked = 0;

    fshs_encoder #(.EMB_LEN(EMB)) fshs_encoder_inst (
        .clk(clk), .rst(rst), .busReq(busReq), .busRdData(busRdData),
        .inBlock(inBlock), .inValid(inValid), .inReady(inReady),
        .sysref(sysref), .outBlock(outBlock), .outValid(outValid),
        .serializerEmphasisLevel(serializerEmphasisLevel),
        .linkActive(linkActive)
    );

    fshs_rx_model #(.EMB_LEN(EMB)) fshs_rx_model_inst (
        .clk(clk), .clr(clr), .rxBlk(outBlock), .rxVld(outValid),
        .words(words), .par(par), .mbSeen(mbSeen), .lineErrs(lineErrs)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        #1;
    endtask

    // Data stands from the cycle after the strobe until the next read
    task automatic rd_chk(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        @(posedge clk);
        busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        cmp(what, exp, busRdData);
    endtask

    task automatic mclr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    // Back to back blocks, then let the last one drain
    task automatic send(input int n, input logic [31:0] seed);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            inBlock <= {seed ^ 32'(i), seed + 32'(i)};
            inValid <= 1'b1;
        end
        @(posedge clk);
        inValid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] fec_word(input logic [25:0] p,
        input logic e);
        logic [31:0] w;
        for (int k = 0; k < 22; k++)
            w[k] = p[25 - k];
        w[26:22] = {p[0], p[1], p[2], p[3], e};
        w[31:27] = 5'h10;
        return w;
    endfunction

    task automatic t_reset();
        cmp("linkActive", 32'h0, {31'h0, linkActive});
        cmp("inReady", 32'h0, {31'h0, inReady});
        rd_chk("ctrl reset", `FSHS_REG_CTRL, 32'h0);
        rd_chk("unmapped read", 8'h20, 32'h0);
    endtask

    task automatic t_emph();
        logic [3:0] v [3] = '{4'h0, 4'h7, 4'hf};
        for (int i = 0; i < 3; i++)
        begin
            bus_wr(`FSHS_REG_CTRL, {20'h0, v[i], 8'h0});
            cmp("emphasis", {28'h0, v[i]}, {28'h0, serializerEmphasisLevel});
        end
    endtask

    task automatic t_fec();
        bus_wr(`FSHS_REG_CTRL, 32'h221);
        cmp("inReady", 32'h1, {31'h0, inReady});
        mclr();
        send(96, 32'h1234_5678);
        cmp("multiblocks", 32'h3, 32'(mbSeen));
        cmp("line errors", 32'h0, 32'(lineErrs));
        cmp("stream 0", fec_word(26'h0, 1'b0), words[0]);
        cmp("stream 1", fec_word(par[0], 1'b1), words[1]);
        cmp("stream 2", fec_word(par[1], 1'b0), words[2]);
        rd_chk("parity reg", `FSHS_REG_FEC, {6'h0, par[2]});
        rd_chk("status", `FSHS_REG_STATUS, 32'h0001_0001);
        rd_chk("mb count", `FSHS_REG_MBCNT, 32'h3);
    endtask

    // Timing restart mid multiblock; the sysref cycle block is dropped
    task automatic t_sysref();
        send(10, 32'hcafe_0000);
        @(posedge clk);
        sysref <= 1'b1;
        clr <= 1'b1;
        inValid <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        clr <= 1'b0;
        inValid <= 1'b0;
        send(64, 32'h0bad_f00d);
        cmp("mb after sysref", 32'h2, 32'(mbSeen));
        cmp("flag mb 0", 32'h0, {31'h0, words[0][22]});
        cmp("stream 1", fec_word(par[0], 1'b1), words[1]);
        cmp("line errors", 32'h0, 32'(lineErrs));
    endtask

    task automatic t_crc();
        bus_wr(`FSHS_REG_CTRL, 32'h0);
        cmp("inReady off", 32'h0, {31'h0, inReady});
        bus_wr(`FSHS_REG_CTRL, 32'h1);
        mclr();
        // First block all zero, so the start-of-multiblock clear is seen
        send(64, 32'h0);
        cmp("crc pilot 0", 32'h80a8_8888, words[0] & 32'hffff_8888);
        cmp("crc pilot 1", 32'h80e8_8888, words[1] & 32'hffff_8888);
        cmp("line errors", 32'h0, 32'(lineErrs));
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_emph();
        t_fec();
        t_sysref();
        t_crc();
        tally_and_finish();
    end

    // Hang guard
    initial
    begin
        #100us;
        miscompares++;
        tally_and_finish();
    end
endmodule
